// >>> tmr_timer16.sv
// Overview of operation
// - Strobe write one resets shared prescaler.
// - Hardware clears strobe after the reset.
// - Writing zero to strobe does nothing.
// - Strobe bit always reads as zero.
// - No clock source selected: counter holds.
// - Compare match sets its channel flag.
// - Counter at zero means BOTTOM.
// - Counter at all ones means MAX.
// - TOP from fixed, compare A or capture.
// - Compare A TOP in PWM modes double buffered, no PWM.
// - One shared high-byte holding register.
// - Low write loads held high plus low.
// - Counter or capture low read copies high byte to holder.
// - Compare reads bypass the holding register.
// - Control registers are plain byte registers.
// - Each request flagged and individually masked.
// - CPU counter write beats clear and count.
`timescale 1ns/10ps
`default_nettype none

module tmr_timer16 (
   input  wire logic               i_mclk,
   input  wire logic               i_sys_rst,
   input  wire tmr_pkg::tmr_io_req_s i_io,
   input  wire logic               i_external_count_pin,
   input  wire logic               i_capture_event,
   output logic [7:0]              o_io_rdata,
   output logic [3:0]              o_irq_req,
   output logic [9:0]              o_prescaler_count,
   output logic                    o_at_bottom,
   output logic                    o_at_max,
   output logic                    o_compare_a_pwm_allowed
);
   import tmr_pkg::*;

   // ==========================================================
   // Registers
   // ==========================================================
   logic [7:0]  ctrl_a_reg;
   logic [7:0]  ctrl_b_reg;
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic [15:0] cmpa_buf_reg;
   logic [15:0] cmpa_reg;
   logic [15:0] cmpb_buf_reg;
   logic [15:0] cmpb_reg;
   logic [15:0] cap_reg;
   logic [7:0]  hold_reg;
   logic [3:0]  flag_reg;
   logic [3:0]  flag_next;
   logic [3:0]  mask_reg;
   logic [6:0]  sfio_keep_reg;
   logic        strobe_reg;
   logic [9:0]  pre_reg;
   logic        ext_now_reg;
   logic        ext_prev_reg;
   tmr_dir_e    dir_reg;
   tmr_dir_e    dir_next;

   // ==========================================================
   // Bus decode
   // ==========================================================
   wire wr_ctrl_a  = i_io.wr && (i_io.addr == ADDR_CTRL_A);
   wire wr_ctrl_b  = i_io.wr && (i_io.addr == ADDR_CTRL_B);
   wire wr_cnt_lo  = i_io.wr && (i_io.addr == ADDR_CNT_LO);
   wire wr_cmpa_lo = i_io.wr && (i_io.addr == ADDR_CMPA_LO);
   wire wr_cmpb_lo = i_io.wr && (i_io.addr == ADDR_CMPB_LO);
   wire wr_cap_lo  = i_io.wr && (i_io.addr == ADDR_CAP_LO);
   wire wr_flag    = i_io.wr && (i_io.addr == ADDR_FLAG);
   wire wr_mask    = i_io.wr && (i_io.addr == ADDR_MASK);
   wire wr_sfio    = i_io.wr && (i_io.addr == ADDR_SFIO);
   // All four high-byte locations land in the one holding register.
   wire wr_any_hi  = i_io.wr && ((i_io.addr == ADDR_CNT_HI)  ||
                                 (i_io.addr == ADDR_CMPA_HI) ||
                                 (i_io.addr == ADDR_CMPB_HI) ||
                                 (i_io.addr == ADDR_CAP_HI));
   wire rd_cnt_lo  = i_io.rd && (i_io.addr == ADDR_CNT_LO);
   wire rd_cap_lo  = i_io.rd && (i_io.addr == ADDR_CAP_LO);
   wire [15:0] wr_word = {hold_reg, i_io.wdata};

   // ==========================================================
   // Mode decode and TOP selection
   // ==========================================================
   wire [3:0] wgm = {ctrl_b_reg[WGM_HI_LSB +: 2], ctrl_a_reg[WGM_LO_LSB +: 2]};
   wire [2:0] cs  = ctrl_b_reg[CS_LSB +: 3];

   wire dual_slope = (wgm == 4'h1) || (wgm == 4'h2) || (wgm == 4'h3) ||
                     (wgm == 4'h8) || (wgm == 4'h9) || (wgm == 4'hA) ||
                     (wgm == 4'hB);
   wire non_pwm    = (wgm == 4'h0) || (wgm == 4'h4) || (wgm == 4'hC) ||
                     (wgm == 4'hD);
   wire top_is_a   = (wgm == 4'h4) || (wgm == 4'h9) || (wgm == 4'hB) ||
                     (wgm == 4'hF);
   wire top_is_cap = (wgm == 4'h8) || (wgm == 4'hA) || (wgm == 4'hC) ||
                     (wgm == 4'hE);
   // The capture register only takes CPU writes while it is acting as TOP.
   wire cap_writable = wr_cap_lo && top_is_cap;
   // Phase and frequency correct modes reload buffers at BOTTOM.
   wire load_at_bottom = (wgm == 4'h8) || (wgm == 4'h9);

   logic [15:0] top_val;
   always_comb begin
      unique case (wgm)
         4'h1, 4'h5: top_val = TOP_8BIT;
         4'h2, 4'h6: top_val = TOP_9BIT;
         4'h3, 4'h7: top_val = TOP_10BIT;
         4'h4, 4'h9, 4'hB, 4'hF: top_val = cmpa_reg;
         4'h8, 4'hA, 4'hC, 4'hE: top_val = cap_reg;
         4'h0, 4'hD: top_val = CNT_MAX;
      endcase
   end

   wire at_bottom = (cnt_reg == CNT_BOTTOM);
   wire at_max    = (cnt_reg == CNT_MAX);
   wire at_top    = (cnt_reg == top_val);

   // ==========================================================
   // Timer tick from the shared prescaler or the count pin
   // ==========================================================
   wire ext_rise = ext_now_reg && !ext_prev_reg;
   wire ext_fall = !ext_now_reg && ext_prev_reg;

   logic tick;
   always_comb begin
      unique case (cs)
         CS_STOP:     tick = 1'b0;
         CS_DIV1:     tick = 1'b1;
         CS_DIV8:     tick = &pre_reg[2:0];
         CS_DIV64:    tick = &pre_reg[5:0];
         CS_DIV256:   tick = &pre_reg[7:0];
         CS_DIV1024:  tick = &pre_reg[9:0];
         CS_EXT_FALL: tick = ext_fall;
         CS_EXT_RISE: tick = ext_rise;
      endcase
   end

   // ==========================================================
   // Counter sequence
   // ==========================================================
   logic ovf_event;
   always_comb begin
      cnt_next  = cnt_reg;
      dir_next  = dir_reg;
      ovf_event = 1'b0;
      if (wr_cnt_lo) begin
         cnt_next = wr_word;
      end else if (tick && dual_slope) begin
         ovf_event = at_bottom && (dir_reg == DIR_DOWN);
         if (top_val == CNT_BOTTOM) begin
            cnt_next = CNT_BOTTOM;
         end else if (dir_reg == DIR_UP) begin
            if (cnt_reg >= top_val) begin
               dir_next = DIR_DOWN;
               cnt_next = cnt_reg - 16'h0001;
            end else begin
               cnt_next = cnt_reg + 16'h0001;
            end
         end else begin
            if (at_bottom) begin
               dir_next = DIR_UP;
               cnt_next = cnt_reg + 16'h0001;
            end else begin
               cnt_next = cnt_reg - 16'h0001;
            end
         end
      end else if (tick) begin
         ovf_event = at_top;
         cnt_next  = at_top ? CNT_BOTTOM : cnt_reg + 16'h0001;
      end
   end

   // ==========================================================
   // Compare matches and flags
   // ==========================================================
   wire match_a = tick && (cnt_reg == cmpa_reg);
   wire match_b = tick && (cnt_reg == cmpb_reg);
   wire buf_load = !non_pwm && tick && (load_at_bottom ? at_bottom : at_top);

   wire [3:0] flag_set = {i_capture_event, match_a, match_b, ovf_event};
   wire [3:0] flag_clr = wr_flag ? i_io.wdata[BIT_CAP_FLAG:BIT_OVF_FLAG] : 4'h0;

   // A set in the same cycle as a software clear wins.
   always_comb begin
      flag_next = (flag_reg & ~flag_clr) | flag_set;
   end

   // ==========================================================
   // Read data
   // ==========================================================
   logic [7:0] rd_data;
   always_comb begin
      unique case (i_io.addr)
         ADDR_CTRL_A:  rd_data = ctrl_a_reg;
         ADDR_CTRL_B:  rd_data = ctrl_b_reg;
         ADDR_CNT_LO:  rd_data = cnt_reg[7:0];
         ADDR_CNT_HI:  rd_data = hold_reg;
         ADDR_CMPA_LO: rd_data = cmpa_buf_reg[7:0];
         ADDR_CMPA_HI: rd_data = cmpa_buf_reg[15:8];
         ADDR_CMPB_LO: rd_data = cmpb_buf_reg[7:0];
         ADDR_CMPB_HI: rd_data = cmpb_buf_reg[15:8];
         ADDR_CAP_LO:  rd_data = cap_reg[7:0];
         ADDR_CAP_HI:  rd_data = hold_reg;
         ADDR_FLAG:    rd_data = {2'b00, flag_reg, 2'b00};
         ADDR_MASK:    rd_data = {2'b00, mask_reg, 2'b00};
         ADDR_SFIO:    rd_data = {sfio_keep_reg, 1'b0};
         default:      rd_data = RST_BYTE;
      endcase
   end

   // ==========================================================
   // Prescaler and strobe
   // ==========================================================
   // The strobe is taken at the write edge and acts one edge later; the
   // strobe bit is tied to zero on reads, whatever the strobe holds.
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         strobe_reg    <= 1'b0;
         sfio_keep_reg <= 7'h00;
         pre_reg       <= PRE_RST;
      end else begin
         if (wr_sfio) begin
            sfio_keep_reg <= i_io.wdata[7:1];
         end
         if (strobe_reg) begin
            strobe_reg <= 1'b0;
            pre_reg    <= PRE_RST;
         end else begin
            strobe_reg <= wr_sfio && i_io.wdata[BIT_PSR_STROBE];
            pre_reg    <= pre_reg + 10'h001;
         end
      end
   end

   // ==========================================================
   // Control, counter and flag registers
   // ==========================================================
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         ctrl_a_reg   <= RST_BYTE;
         ctrl_b_reg   <= RST_BYTE;
         mask_reg     <= 4'h0;
         flag_reg     <= 4'h0;
         cnt_reg      <= RST_WORD;
         dir_reg      <= DIR_UP;
         ext_now_reg  <= 1'b0;
         ext_prev_reg <= 1'b0;
      end else begin
         if (wr_ctrl_a) begin
            ctrl_a_reg <= i_io.wdata;
         end
         if (wr_ctrl_b) begin
            ctrl_b_reg <= i_io.wdata;
         end
         if (wr_mask) begin
            mask_reg <= i_io.wdata[BIT_CAP_FLAG:BIT_OVF_FLAG];
         end
         flag_reg     <= flag_next;
         cnt_reg      <= cnt_next;
         dir_reg      <= dir_next;
         ext_now_reg  <= i_external_count_pin;
         ext_prev_reg <= ext_now_reg;
      end
   end

   // ==========================================================
   // Compare, capture and holding registers
   // ==========================================================
   // Outside PWM modes the active compare value follows the buffer at once.
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         cmpa_buf_reg <= RST_WORD;
         cmpa_reg     <= RST_WORD;
         cmpb_buf_reg <= RST_WORD;
         cmpb_reg     <= RST_WORD;
      end else begin
         if (wr_cmpa_lo) begin
            cmpa_buf_reg <= wr_word;
         end
         if (wr_cmpb_lo) begin
            cmpb_buf_reg <= wr_word;
         end
         if (non_pwm && wr_cmpa_lo) begin
            cmpa_reg <= wr_word;
         end else if (non_pwm || buf_load) begin
            cmpa_reg <= cmpa_buf_reg;
         end
         if (non_pwm && wr_cmpb_lo) begin
            cmpb_reg <= wr_word;
         end else if (non_pwm || buf_load) begin
            cmpb_reg <= cmpb_buf_reg;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         cap_reg  <= RST_WORD;
         hold_reg <= RST_BYTE;
      end else begin
         if (cap_writable) begin
            cap_reg <= wr_word;
         end else if (i_capture_event && !top_is_cap) begin
            cap_reg <= cnt_reg;
         end
         if (wr_any_hi) begin
            hold_reg <= i_io.wdata;
         end else if (rd_cnt_lo) begin
            hold_reg <= cnt_reg[15:8];
         end else if (rd_cap_lo) begin
            hold_reg <= cap_reg[15:8];
         end
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_io_rdata              <= RST_BYTE;
         o_irq_req               <= 4'h0;
         o_prescaler_count       <= PRE_RST;
         o_at_bottom             <= 1'b1;
         o_at_max                <= 1'b0;
         o_compare_a_pwm_allowed <= 1'b1;
      end else begin
         o_io_rdata              <= i_io.rd ? rd_data : RST_BYTE;
         o_irq_req               <= flag_next & mask_reg;
         o_prescaler_count       <= strobe_reg ? PRE_RST : pre_reg + 10'h001;
         o_at_bottom             <= (cnt_next == CNT_BOTTOM);
         o_at_max                <= (cnt_next == CNT_MAX);
         o_compare_a_pwm_allowed <= !(top_is_a && !non_pwm);
      end
   end

endmodule : tmr_timer16

`default_nettype wire

// >>> tmr_pkg.sv
`default_nettype none
package tmr_pkg;

   // ==========================================================
   // Register addresses on the 8-bit I/O bus
   // ==========================================================
   localparam int unsigned ADDR_W = 6;

   localparam logic [ADDR_W-1:0] ADDR_CTRL_A  = 6'h00;
   localparam logic [ADDR_W-1:0] ADDR_CTRL_B  = 6'h01;
   localparam logic [ADDR_W-1:0] ADDR_CNT_LO  = 6'h02;
   localparam logic [ADDR_W-1:0] ADDR_CNT_HI  = 6'h03;
   localparam logic [ADDR_W-1:0] ADDR_CMPA_LO = 6'h04;
   localparam logic [ADDR_W-1:0] ADDR_CMPA_HI = 6'h05;
   localparam logic [ADDR_W-1:0] ADDR_CMPB_LO = 6'h06;
   localparam logic [ADDR_W-1:0] ADDR_CMPB_HI = 6'h07;
   localparam logic [ADDR_W-1:0] ADDR_CAP_LO  = 6'h08;
   localparam logic [ADDR_W-1:0] ADDR_CAP_HI  = 6'h09;
   localparam logic [ADDR_W-1:0] ADDR_FLAG    = 6'h0A;
   localparam logic [ADDR_W-1:0] ADDR_MASK    = 6'h0B;
   localparam logic [ADDR_W-1:0] ADDR_SFIO    = 6'h0C;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int unsigned BIT_PSR_STROBE = 0;
   localparam int unsigned BIT_CAP_FLAG   = 5;
   localparam int unsigned BIT_CMPA_FLAG  = 4;
   localparam int unsigned BIT_CMPB_FLAG  = 3;
   localparam int unsigned BIT_OVF_FLAG   = 2;
   localparam int unsigned CS_LSB         = 0;
   localparam int unsigned WGM_HI_LSB     = 3;
   localparam int unsigned WGM_LO_LSB     = 0;

   // ==========================================================
   // Reset values and fixed limits
   // ==========================================================
   localparam logic [7:0]  RST_BYTE   = 8'h00;
   localparam logic [15:0] RST_WORD   = 16'h0000;
   localparam logic [15:0] CNT_BOTTOM = 16'h0000;
   localparam logic [15:0] CNT_MAX    = 16'hFFFF;
   localparam logic [15:0] TOP_8BIT   = 16'h00FF;
   localparam logic [15:0] TOP_9BIT   = 16'h01FF;
   localparam logic [15:0] TOP_10BIT  = 16'h03FF;
   localparam logic [9:0]  PRE_RST    = 10'h000;

   // ==========================================================
   // Clock select codes
   // ==========================================================
   localparam logic [2:0] CS_STOP     = 3'h0;
   localparam logic [2:0] CS_DIV1     = 3'h1;
   localparam logic [2:0] CS_DIV8     = 3'h2;
   localparam logic [2:0] CS_DIV64    = 3'h3;
   localparam logic [2:0] CS_DIV256   = 3'h4;
   localparam logic [2:0] CS_DIV1024  = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;

   typedef enum logic {DIR_UP, DIR_DOWN} tmr_dir_e;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        wdata;
   } tmr_io_req_s;

endpackage : tmr_pkg

`default_nettype wire

// >>> tmr_chk.sv
`timescale 1ns/10ps
`default_nettype none
module tmr_chk (
   input wire logic                 i_mclk,
   input wire logic                 i_sys_rst,
   input wire tmr_pkg::tmr_io_req_s i_io,
   input wire logic                 i_external_count_pin,
   input wire logic                 i_capture_event,
   input wire logic [7:0]           o_io_rdata,
   input wire logic [3:0]           o_irq_req,
   input wire logic [9:0]           o_prescaler_count,
   input wire logic                 o_at_bottom,
   input wire logic                 o_at_max,
   input wire logic                 o_compare_a_pwm_allowed
);
   import tmr_pkg::*;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   // ==========================================================
   // Access steps
   // ==========================================================
   // The request is passed in so that it is sampled with the property.
   function automatic logic acc(input tmr_io_req_s io, input logic w, input logic [5:0] a);
      return (w ? io.wr : io.rd) && io.addr == a;
   endfunction : acc
   sequence hold_load;
      i_io.wr && (i_io.addr == ADDR_CNT_HI || i_io.addr == ADDR_CMPA_HI
         || i_io.addr == ADDR_CMPB_HI || i_io.addr == ADDR_CAP_HI);
   endsequence
   sequence cnt_wr(logic [15:0] v);
      (acc(i_io, 1'b1, ADDR_CNT_HI) && i_io.wdata == v[15:8])
      ##1 (acc(i_io, 1'b1, ADDR_CNT_LO) && i_io.wdata == v[7:0]);
   endsequence
   sequence cmpa_then_holder;
      acc(i_io, 1'b1, ADDR_CMPA_HI) ##1 acc(i_io, 1'b1, ADDR_CMPA_LO)
      ##1 acc(i_io, 1'b1, ADDR_CNT_HI) ##1 acc(i_io, 1'b0, ADDR_CMPA_HI);
   endsequence
   // ==========================================================
   // Assertions
   // ==========================================================
   psr_reset_a: assert property (
      acc(i_io, 1'b1, ADDR_SFIO) && i_io.wdata[BIT_PSR_STROBE] |-> ##2 o_prescaler_count == PRE_RST)
      else $error("prescaler not cleared by strobe");
   psr_zero_a: assert property (
      acc(i_io, 1'b1, ADDR_SFIO) && !i_io.wdata[BIT_PSR_STROBE]
      && !$past(acc(i_io, 1'b1, ADDR_SFIO))
      |-> ##2 o_prescaler_count == 10'($past(o_prescaler_count, 2) + 10'h002))
      else $error("zero strobe write disturbed prescaler");
   strobe_read_a: assert property (
      acc(i_io, 1'b0, ADDR_SFIO) |=> !o_io_rdata[BIT_PSR_STROBE])
      else $error("strobe bit read as one");
   holder_shared_a: assert property (
      hold_load ##1 acc(i_io, 1'b0, ADDR_CNT_HI) |=> o_io_rdata == $past(i_io.wdata, 2))
      else $error("holding register not shared");
   cmp_direct_a: assert property (
      cmpa_then_holder |=> o_io_rdata == $past(i_io.wdata, 4))
      else $error("compare high read used holding register");
   low_commit_a: assert property (
      acc(i_io, 1'b1, ADDR_CMPB_HI) ##1 acc(i_io, 1'b1, ADDR_CMPB_LO)
      ##1 acc(i_io, 1'b0, ADDR_CMPB_LO)
      |=> o_io_rdata == $past(i_io.wdata, 2))
      else $error("low byte write not committed");
   bottom_seen_a: assert property (cnt_wr(CNT_BOTTOM) |-> ##[1:2] o_at_bottom)
      else $error("bottom not flagged");
   max_seen_a: assert property (cnt_wr(CNT_MAX) |-> ##[1:2] o_at_max)
      else $error("max not flagged");
   mask_gate_a: assert property (
      acc(i_io, 1'b1, ADDR_MASK) && i_io.wdata[5:2] == 4'h0 |-> ##2 o_irq_req == 4'h0)
      else $error("masked request still raised");
endmodule : tmr_chk
bind tmr_timer16 tmr_chk tmr_chk_inst (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_io(i_io),
   .i_external_count_pin(i_external_count_pin), .i_capture_event(i_capture_event),
   .o_io_rdata(o_io_rdata), .o_irq_req(o_irq_req), .o_prescaler_count(o_prescaler_count),
   .o_at_bottom(o_at_bottom), .o_at_max(o_at_max),
   .o_compare_a_pwm_allowed(o_compare_a_pwm_allowed));
`default_nettype wire

// >>> tmr_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module tmr_cpu_model (
   input  wire logic              i_mclk,
   output var tmr_pkg::tmr_io_req_s o_io
);
   import tmr_pkg::*;
   initial o_io = '{wr: 1'b0, rd: 1'b0, addr: 6'h00, wdata: 8'h00};
   // ==========================================================
   // Bus cycles
   // ==========================================================
   // One access per cycle, changed just after the edge that took the last one.
   task automatic go(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      o_io = '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge i_mclk);
      #1;
   endtask : go
   // Released lines show the inverse so a stale value is never mistaken for a live one.
   task automatic idle();
      o_io = '{wr: 1'b0, rd: 1'b0, addr: ~o_io.addr, wdata: ~o_io.wdata};
      @(posedge i_mclk);
      #1;
   endtask : idle
   // The pair runs without a break, as with interrupts blocked.
   task automatic wr16(input logic [ADDR_W-1:0] lo, input logic [15:0] v);
      go(1'b1, lo + 6'h01, v[15:8]);
      go(1'b1, lo, v[7:0]);
      idle();
   endtask : wr16
endmodule : tmr_cpu_model
`default_nettype wire

// >>> timer16_register_access_test.sv
`timescale 1ns/10ps
`default_nettype none
module timer16_register_access_test;
   import tmr_pkg::*;
   logic        i_mclk;
   logic        i_sys_rst;
   tmr_io_req_s io;
   logic        cap_evt;
   logic [7:0]  rdata;
   logic [3:0]  irq;
   logic [9:0]  pre_cnt;
   logic        at_bottom;
   logic        at_max;
   logic        pwm_ok;
   logic [7:0]  exp_q[$];
   logic        pend = 1'b0;
   logic [15:0] e16;
   logic [15:0] v;
   logic [15:0] w;
   logic [3:0]  m;
   int          n_fail;
   int          n_checks;
   int          seed;
   int          i;
   tmr_cpu_model tmr_cpu_model_inst (.i_mclk(i_mclk), .o_io(io));
   tmr_timer16 tmr_timer16_inst (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_io(io),
      .i_external_count_pin(1'b0), .i_capture_event(cap_evt), .o_io_rdata(rdata),
      .o_irq_req(irq), .o_prescaler_count(pre_cnt), .o_at_bottom(at_bottom),
      .o_at_max(at_max), .o_compare_a_pwm_allowed(pwm_ok));
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   // ==========================================================
   // Checking
   // ==========================================================
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done
   // Read data stands one cycle after the read edge, so it is taken mid-cycle.
   always @(negedge i_mclk) begin
      if (pend) begin
         e16 = (exp_q.size() > 0) ? {8'h00, exp_q.pop_front()} : 16'hFFFF;
         check({8'h00, rdata}, e16);
      end
      pend = io.rd;
   end
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      tmr_cpu_model_inst.go(1'b0, a, e);
   endtask : rd
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      tmr_cpu_model_inst.go(1'b1, a, d);
   endtask : wr
   // Waits for {max, bottom, requests}; running out of cycles ends the run.
   task automatic wait_for(input logic [5:0] want);
      int k;
      for (k = 0; k < 100 && {at_max, at_bottom, irq} !== want; k++) begin
         @(posedge i_mclk);
         #1;
      end
      check({10'h000, at_max, at_bottom, irq}, {10'h000, want});
      if (k == 100) test_done();
   endtask : wait_for
   // ==========================================================
   // Scenarios
   // ==========================================================
   initial begin
      seed = 32'h18C149BA;
      i_sys_rst = 1'b1;
      cap_evt = 1'b0;
      n_fail = 0;
      n_checks = 0;
      repeat (16) @(posedge i_mclk);
      #1;
      i_sys_rst = 1'b0;
      check({13'h0000, at_bottom, at_max, pwm_ok}, 16'h0005);
      for (i = 0; i < 14; i++) rd(6'(i), 8'h00);
      for (i = 0; i < 16; i++) begin
         m = 4'(i);
         wr(ADDR_CTRL_A, {6'h00, m[1:0]});
         wr(ADDR_CTRL_B, {3'h0, m[3:2], CS_STOP});
         rd(ADDR_CTRL_A, {6'h00, m[1:0]});
         rd(ADDR_CTRL_B, {3'h0, m[3:2], CS_STOP});
         tmr_cpu_model_inst.idle();
         check({15'h0000, pwm_ok}, {15'h0000, !(m inside {4'h9, 4'hB, 4'hF})});
      end
      wr(ADDR_CTRL_A, 8'h00);
      wr(ADDR_CTRL_B, 8'h00);
      v = {4'h1, 12'($random(seed))};
      w = 16'($random(seed));
      tmr_cpu_model_inst.wr16(ADDR_CNT_LO, v);
      repeat (4) tmr_cpu_model_inst.idle();
      rd(ADDR_CNT_LO, v[7:0]);
      rd(ADDR_CNT_HI, v[15:8]);
      wr(ADDR_CMPB_HI, w[15:8]);
      rd(ADDR_CNT_HI, w[15:8]);
      wr(ADDR_CMPA_HI, w[15:8]);
      wr(ADDR_CMPA_LO, w[7:0]);
      wr(ADDR_CNT_HI, ~w[15:8]);
      rd(ADDR_CMPA_HI, w[15:8]);
      rd(ADDR_CMPA_LO, w[7:0]);
      rd(ADDR_CNT_HI, ~w[15:8]);
      wr(ADDR_CMPB_HI, w[7:0]);
      wr(ADDR_CMPB_LO, w[15:8]);
      rd(ADDR_CMPB_LO, w[15:8]);
      rd(ADDR_CMPB_HI, w[7:0]);
      tmr_cpu_model_inst.idle();
      cap_evt = 1'b1;
      wr(ADDR_MASK, 8'h20);
      cap_evt = 1'b0;
      tmr_cpu_model_inst.idle();
      wait_for(6'b001000);
      rd(ADDR_CAP_LO, v[7:0]);
      rd(ADDR_CAP_HI, v[15:8]);
      rd(ADDR_FLAG, 8'h20);
      wr(ADDR_FLAG, 8'h20);
      wr(ADDR_MASK, 8'h00);
      rd(ADDR_FLAG, 8'h00);
      tmr_cpu_model_inst.wr16(ADDR_CNT_LO, CNT_MAX);
      wait_for(6'b100000);
      tmr_cpu_model_inst.wr16(ADDR_CNT_LO, CNT_BOTTOM);
      wait_for(6'b010000);
      tmr_cpu_model_inst.wr16(ADDR_CMPA_LO, v + 16'h0004);
      tmr_cpu_model_inst.wr16(ADDR_CMPB_LO, v + 16'h0008);
      tmr_cpu_model_inst.wr16(ADDR_CNT_LO, v);
      wr(ADDR_MASK, 8'h18);
      wr(ADDR_CTRL_B, {5'h00, CS_DIV1});
      tmr_cpu_model_inst.idle();
      wait_for(6'b000110);
      tmr_cpu_model_inst.wr16(ADDR_CNT_LO, CNT_MAX);
      wr(ADDR_CTRL_B, {5'h00, CS_STOP});
      rd(ADDR_FLAG, 8'h1C);
      wr(ADDR_SFIO, 8'h01);
      rd(ADDR_SFIO, 8'h00);
      check({6'h00, pre_cnt}, 16'h0000);
      wr(ADDR_SFIO, 8'h00);
      rd(ADDR_SFIO, 8'h00);
      rd(6'h3F, 8'h00);
      tmr_cpu_model_inst.idle();
      tmr_cpu_model_inst.idle();
      test_done();
   end
   initial begin
      #200000;
      n_fail++;
      test_done();
   end
endmodule : timer16_register_access_test
`default_nettype wire
